// ### include/fcs_pkg.sv
// Constants, field layout and decode tables for the start-up / closed-loop configuration bank
package fcs_pkg;

	// ----------------------------------------------------------------
	// Register map (byte offsets on the host register port)
	// ----------------------------------------------------------------
	localparam logic [7:0]  STARTUP_PROFILE_B_OFS  = 8'h84;
	localparam logic [7:0]  SPEED_LOOP_CONFIG_A_OFS = 8'h88;
	localparam logic [31:0] STARTUP_PROFILE_B_RST  = 32'h00000000;
	localparam logic [31:0] SPEED_LOOP_CONFIG_A_RST = 32'h00000000;
	localparam logic [31:0] UNMAPPED_READ          = 32'h00000000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PCT_LSB       = 4;  // initial_cycle_rate_pct, 4 bits
	localparam int PCT_W         = 4;
	localparam int SRC_BIT       = 3;  // initial_cycle_rate_source
	localparam int RAMP_LSB      = 0;  // theta error ramp rate, 3 bits
	localparam int RAMP_W        = 3;
	localparam int OVERMOD_BIT   = 30;
	localparam int ACCEL_LSB     = 25; // run_accel_limit, 5 bits
	localparam int ACCEL_W       = 5;
	localparam int DEC_SRC_BIT   = 24; // run_decel_source
	localparam int DECEL_LSB     = 19; // run_decel_limit, 5 bits
	localparam int DECEL_W       = 5;

	localparam logic [4:0] ACCEL_NO_LIMIT = 5'h1F;

	// ----------------------------------------------------------------
	// Decode tables
	// ----------------------------------------------------------------
	// Percent of maximum speed, in half-percent units
	localparam logic [6:0] PCT_X2 [16] = '{7'h02, 7'h04, 7'h06, 7'h0A, 7'h0F, 7'h14, 7'h19, 7'h1E,
		7'h23, 7'h28, 7'h32, 7'h3C, 7'h46, 7'h50, 7'h5A, 7'h64};
	// Angle merge ramp rate, in 0.01 deg/ms units
	localparam logic [7:0] RAMP_X100 [8] = '{8'h01, 8'h05, 8'h0A, 8'h0F, 8'h14, 8'h32, 8'h64, 8'hC8};
	// Speed change limit, in 0.5 Hz/s units; last entry means no limit
	localparam logic [17:0] ACCEL_X2 [32] = '{18'h00001, 18'h00002, 18'h00005, 18'h0000A, 18'h0000F,
		18'h00014, 18'h00028, 18'h00050, 18'h00078, 18'h000A0, 18'h000C8, 18'h00190, 18'h00258,
		18'h00320, 18'h003E8, 18'h004B0, 18'h00578, 18'h00640, 18'h00708, 18'h007D0, 18'h00FA0,
		18'h01F40, 18'h02EE0, 18'h03E80, 18'h04E20, 18'h09C40, 18'h0EA60, 18'h13880, 18'h186A0,
		18'h1D4C0, 18'h222E0, 18'h00000};

endpackage

// ### logic/fcs_word.sv
// One read/write configuration word with a load strobe and a reset value
`timescale 1ns/1ps
module fcs_word #(
	parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        load,
	input  wire logic [31:0] wdata,
	output logic      [31:0] q
);

	// ------------------------------------------------
	// Storage
	// ------------------------------------------------
	// All bits are stored as written, reserved ones too, so a read returns them
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= RESET_VALUE;
		end else if (load) begin
			q <= wdata;
		end
	end

endmodule

// ### logic/fcs_cfg.sv
// Start-up and closed-loop configuration bank with field decode for the motor control core
//
// How it works
// - First-cycle percent code 0h..Fh decodes 1%..50% of maximum speed via table.
// - Selector bit 3 low gives 0 Hz first cycle, high uses percent field.
// - Angle merge ramp code 0h..7h decodes 0.01..2 deg/ms via table.
// - Closed-loop word sits at 88h and resets to all zeros.
// - Bit 30 of closed-loop word turns overmodulation on when set.
// - Bit 24 low means deceleration is limited by the separate decel field.
// - Acceleration code 0h..1Eh gives 0.5..70000 Hz/s, 1Fh no limit; bit 24 copies it.
`timescale 1ns/1ps
module fcs_cfg (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             reg_rvalid,
	output logic      [6:0]  initial_cycle_rate_pct,
	output logic      [6:0]  first_cycle_rate,
	output logic      [7:0]  theta_ramp_rate,
	output logic             overmod_en,
	output logic      [17:0] run_accel_limit,
	output logic             accel_unlimited,
	output logic             run_decel_source,
	output logic      [4:0]  run_decel_limit,
	output logic      [17:0] decel_rate,
	output logic             decel_unlimited
);
	import fcs_pkg::*;

	// ------------------------------------------------
	// State
	// ------------------------------------------------
	typedef struct packed {
		logic [6:0]  pct;
		logic [6:0]  first;
		logic [7:0]  ramp;
		logic        overmod;
		logic [17:0] accel;
		logic        acc_unl;
		logic        dec_src;
		logic [4:0]  dec_code;
		logic [17:0] dec_rate;
		logic        dec_unl;
		logic [31:0] rdata;
		logic        rvalid;
	} fcs_state_t;

	fcs_state_t  state;
	fcs_state_t  next_state;
	logic [31:0] startup_q;
	logic [31:0] loop_q;
	logic        hit_startup;
	logic        hit_loop;
	logic [4:0]  acc_code;

	// ------------------------------------------------
	// Address decode and storage
	// ------------------------------------------------
	assign hit_startup = (reg_addr == STARTUP_PROFILE_B_OFS);
	assign hit_loop    = (reg_addr == SPEED_LOOP_CONFIG_A_OFS);

	fcs_word #(.RESET_VALUE(STARTUP_PROFILE_B_RST)) u_startup (
		.sys_clk (sys_clk),
		.rst     (rst),
		.load    (reg_wr && hit_startup),
		.wdata   (reg_wdata),
		.q       (startup_q)
	);

	// Zero reset value keeps overmodulation off and acceleration at the slowest rate
	fcs_word #(.RESET_VALUE(SPEED_LOOP_CONFIG_A_RST)) u_loop (
		.sys_clk (sys_clk),
		.rst     (rst),
		.load    (reg_wr && hit_loop),
		.wdata   (reg_wdata),
		.q       (loop_q)
	);

	assign acc_code = loop_q[ACCEL_LSB +: ACCEL_W];

	// ------------------------------------------------
	// Decode and read-back
	// ------------------------------------------------
	// Decode is registered so every output comes from a flip-flop; one cycle behind the word
	always_comb begin
		next_state = state;
		next_state.pct = PCT_X2[startup_q[PCT_LSB +: PCT_W]];
		// Align style start-ups begin from standstill unless the selector asks otherwise
		next_state.first = startup_q[SRC_BIT] ? PCT_X2[startup_q[PCT_LSB +: PCT_W]] : 7'h00;
		next_state.ramp = RAMP_X100[startup_q[RAMP_LSB +: RAMP_W]];
		next_state.overmod = loop_q[OVERMOD_BIT];
		next_state.accel = ACCEL_X2[acc_code];
		next_state.acc_unl = (acc_code == ACCEL_NO_LIMIT);
		next_state.dec_src = loop_q[DEC_SRC_BIT];
		next_state.dec_code = loop_q[DECEL_LSB +: DECEL_W];
		// Decel rate is only decoded when it follows acceleration; else the core uses the code
		if (loop_q[DEC_SRC_BIT]) begin
			next_state.dec_rate = ACCEL_X2[acc_code];
			next_state.dec_unl = (acc_code == ACCEL_NO_LIMIT);
		end else begin
			next_state.dec_rate = 18'h00000;
			next_state.dec_unl = 1'b0;
		end
		next_state.rvalid = reg_rd;
		if (!reg_rd) begin
			next_state.rdata = state.rdata;
		end else if (hit_startup) begin
			next_state.rdata = startup_q;
		end else if (hit_loop) begin
			next_state.rdata = loop_q;
		end else begin
			next_state.rdata = UNMAPPED_READ; // Unmapped reads answer zero
		end
	end

	// Register the whole state
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------
	// Outputs
	// ------------------------------------------------
	assign reg_rdata              = state.rdata;
	assign reg_rvalid             = state.rvalid;
	assign initial_cycle_rate_pct = state.pct;
	assign first_cycle_rate       = state.first;
	assign theta_ramp_rate        = state.ramp;
	assign overmod_en             = state.overmod;
	assign run_accel_limit        = state.accel;
	assign accel_unlimited        = state.acc_unl;
	assign run_decel_source       = state.dec_src;
	assign run_decel_limit        = state.dec_code;
	assign decel_rate             = state.dec_rate;
	assign decel_unlimited        = state.dec_unl;

	// ------------------------------------------------
	// Assertions
	// ------------------------------------------------
	property p_pct_max;
		@(posedge sys_clk) disable iff (rst)
		(reg_wr && hit_startup && reg_wdata[PCT_LSB +: PCT_W] == 4'hF) ##1 !reg_wr |=> initial_cycle_rate_pct == 7'h64;
	endproperty
	a_pct_max: assert property (p_pct_max) else $error("Percent code F not 50 percent");

	property p_first_zero;
		@(posedge sys_clk) disable iff (rst)
		!startup_q[SRC_BIT] |=> first_cycle_rate == 7'h00;
	endproperty
	a_first_zero: assert property (p_first_zero) else $error("First cycle rate not zero");

	property p_first_sel;
		@(posedge sys_clk) disable iff (rst)
		startup_q[SRC_BIT] |=> first_cycle_rate == initial_cycle_rate_pct;
	endproperty
	a_first_sel: assert property (p_first_sel) else $error("First cycle rate not from percent");

	property p_ramp_max;
		@(posedge sys_clk) disable iff (rst)
		startup_q[RAMP_LSB +: RAMP_W] == 3'h7 |=> theta_ramp_rate == 8'hC8;
	endproperty
	a_ramp_max: assert property (p_ramp_max) else $error("Ramp code 7 not 2 deg/ms");

	property p_loop_reset;
		@(posedge sys_clk) $fell(rst) |-> loop_q == 32'h00000000;
	endproperty
	a_loop_reset: assert property (p_loop_reset) else $error("Closed-loop word not zero after reset");

	property p_loop_read;
		@(posedge sys_clk) disable iff (rst)
		(reg_rd && hit_loop && !reg_wr) |=> reg_rvalid && reg_rdata == $past(loop_q);
	endproperty
	a_loop_read: assert property (p_loop_read) else $error("Closed-loop read data wrong");

	property p_overmod;
		@(posedge sys_clk) disable iff (rst)
		(reg_wr && hit_loop) ##2 !$past(reg_wr) |-> overmod_en == $past(reg_wdata[OVERMOD_BIT], 2);
	endproperty
	a_overmod: assert property (p_overmod) else $error("Overmodulation enable not following write");

	property p_decel_sep;
		@(posedge sys_clk) disable iff (rst)
		!loop_q[DEC_SRC_BIT] |=> decel_rate == 18'h00000 && !decel_unlimited && !run_decel_source;
	endproperty
	a_decel_sep: assert property (p_decel_sep) else $error("Decel not from separate field");

	property p_accel_unl;
		@(posedge sys_clk) disable iff (rst)
		acc_code == ACCEL_NO_LIMIT |=> accel_unlimited && run_accel_limit == 18'h00000;
	endproperty
	a_accel_unl: assert property (p_accel_unl) else $error("Accel code 1F not unlimited");

	property p_decel_copy;
		@(posedge sys_clk) disable iff (rst)
		loop_q[DEC_SRC_BIT] |=> decel_rate == run_accel_limit && decel_unlimited == accel_unlimited;
	endproperty
	a_decel_copy: assert property (p_decel_copy) else $error("Decel not following accel");

	c_overmod_on: cover property (@(posedge sys_clk) disable iff (rst) $rose(overmod_en));
	c_decel_copy: cover property (@(posedge sys_clk) disable iff (rst) run_decel_source && decel_unlimited);
	c_first_sel:  cover property (@(posedge sys_clk) disable iff (rst) first_cycle_rate == 7'h64);
	c_unmapped:   cover property (@(posedge sys_clk) disable iff (rst) reg_rd && !hit_loop && !hit_startup);

endmodule

// ### test/test_fcs_cfg.sv
// Self-checking testbench for the start-up / closed-loop configuration bank
`timescale 1ns/1ps
module test_fcs_cfg;
	logic        sys_clk, rst, reg_wr, reg_rd, reg_rvalid;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [6:0]  initial_cycle_rate_pct, first_cycle_rate;
	logic [7:0]  theta_ramp_rate;
	logic        overmod_en, accel_unlimited, run_decel_source, decel_unlimited;
	logic [17:0] run_accel_limit, decel_rate;
	logic [4:0]  run_decel_limit;
	int          bad_count = 0;
	int          cmp_count = 0;
	// Expected decodes: percent x2, deg/ms x100, Hz/s x2 (0 stands for no limit)
	int pct_tbl [16] = '{2, 4, 6, 10, 15, 20, 25, 30, 35, 40, 50, 60, 70, 80, 90, 100};
	int ramp_tbl [8] = '{1, 5, 10, 15, 20, 50, 100, 200};
	int acc_tbl [32] = '{1, 2, 5, 10, 15, 20, 40, 80, 120, 160, 200, 400, 600, 800, 1000, 1200, 1400, 1600,
		1800, 2000, 4000, 8000, 12000, 16000, 20000, 40000, 60000, 80000, 100000, 120000, 140000, 0};

	fcs_cfg fcs_cfg_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.initial_cycle_rate_pct(initial_cycle_rate_pct), .first_cycle_rate(first_cycle_rate),
		.theta_ramp_rate(theta_ramp_rate), .overmod_en(overmod_en), .run_accel_limit(run_accel_limit),
		.accel_unlimited(accel_unlimited), .run_decel_source(run_decel_source),
		.run_decel_limit(run_decel_limit), .decel_rate(decel_rate), .decel_unlimited(decel_unlimited));

	// ----------------------------------------------------------------
	// Bus tasks and checking
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Write strobe is one cycle; decoded outputs are settled after the following edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask

	// Read data comes with a one-cycle valid pulse right after the taking edge
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk("rvalid", 1, reg_rvalid);
		chk("rdata", exp, reg_rdata);
		@(posedge sys_clk);
		#1;
		chk("rvalid_drop", 0, reg_rvalid);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_state();
		rd(8'h88, 0);
		rd(8'h84, 0);
		chk("overmod", 0, overmod_en);
		chk("accel", 1, run_accel_limit);
		$display("test reset_state done");
	endtask

	// Every first-cycle percent code with the selector toggling, ramp codes cycling
	task automatic t_startup();
		logic [31:0] d;
		for (int i = 0; i < 16; i++) begin
			d = {24'h0, 4'(i), 1'(i), 3'(i)};
			wr(8'h84, d);
			chk("pct", pct_tbl[i], initial_cycle_rate_pct);
			chk("first", (i % 2) ? pct_tbl[i] : 0, first_cycle_rate);
			chk("ramp", ramp_tbl[i % 8], theta_ramp_rate);
			rd(8'h84, d);
		end
		$display("test startup done");
	endtask

	// Every acceleration code; decel source and overmodulation toggle alongside
	task automatic t_closed();
		logic [31:0] d;
		logic [4:0]  c;
		for (int i = 0; i < 32; i++) begin
			c = 5'(i);
			// Reserved bits 31 and 0 are always written as zero
			d = {1'b0, 1'(i >> 1), c, 1'(i), c ^ 5'h15, 19'h5A5A6};
			wr(8'h88, d);
			chk("overmod", (i >> 1) % 2, overmod_en);
			chk("accel", acc_tbl[i], run_accel_limit);
			chk("unlim", i == 31, accel_unlimited);
			chk("dsrc", i % 2, run_decel_source);
			chk("dlim", c ^ 5'h15, run_decel_limit);
			chk("drate", (i % 2) ? acc_tbl[i] : 0, decel_rate);
			chk("dunlim", (i % 2) && i == 31, decel_unlimited);
			rd(8'h88, d);
		end
		$display("test closed_loop done");
	endtask

	// Unmapped write must not land anywhere; unmapped read returns zero
	task automatic t_unmapped();
		wr(8'h88, 32'h40000000);
		wr(8'h8C, 32'h3FFFFFFE);
		rd(8'h8C, 0);
		rd(8'h88, 32'h40000000);
		// Start-up word still holds the last value of the start-up sweep
		rd(8'h84, 32'h000000FF);
		chk("overmod", 1, overmod_en);
		$display("test unmapped done");
	endtask

	// A second reset in mid-run clears both words and the decodes
	task automatic t_rereset();
		wr(8'h88, 32'h7F000000);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		// Still the reset image: decode only refills at the first edge after release
		chk("accel_rst", 0, run_accel_limit);
		chk("overmod_rst", 0, overmod_en);
		@(posedge sys_clk);
		#1;
		chk("accel", 1, run_accel_limit);
		chk("overmod", 0, overmod_en);
		chk("dsrc", 0, run_decel_source);
		rd(8'h88, 0);
		rd(8'h84, 0);
		$display("test rereset done");
	endtask

	// ----------------------------------------------------------------
	// Clock, sequence, watchdog and verdict
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset_state();
		t_startup();
		t_closed();
		t_unmapped();
		t_rereset();
		summarize();
	end

	// Roughly 330 cycles expected; a hang past 4000 ends the run
	initial begin
		repeat (4000) @(posedge sys_clk);
		bad_count++;
		summarize();
	end
endmodule
